// ### hw/aclink_fifo_dma_status.sv
// The AXI4-Lite slave port was decided locally.
module aclink_fifo_dma_status
    import aclink_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // AXI4-Lite write
    input wire logic [15:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [15:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Slot FIFO state, one bit per channel
    input wire logic [7:0] chanFull,
    input wire logic [7:0] chanNonEmpty,
    // DMA side
    input wire logic [7:0] dmaChanEnable,
    input wire logic [7:0] sampleAccess,
    output logic [7:0] dmaRequest,
    // PCM output samples
    input wire logic bigEndian,
    output logic [15:0] pcmSampleLeft,
    output logic [15:0] pcmSampleRight,
    output logic pcmSampleValid
);

    reg_port_if rp();

    axil_slave_port u_port
    (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .rp(rp.port)
    );

    logic [1:0] mapMode_q, mapMode_d;
    logic [7:0] dmaPending_q, dmaPending_d;
    logic [15:0] pcmLeft_q, pcmLeft_d, pcmRight_q, pcmRight_d;
    logic pcmValid_q, pcmValid_d;
    logic [7:0] mapMask;
    logic [7:0] pendSet;
    logic [7:0] pendClr;
    logic [31:0] fifoStatus;
    logic pcmWrite, pcmRead, mapWrite;

    // ----------------------------------------
    // Status word
    // ----------------------------------------
    always_comb
    begin
        fifoStatus = 32'h0000_0000;
        fifoStatus[MODEM_TX_FULL_BIT] = chanFull[CH_MODEM_TX];
        fifoStatus[AUDIO_FULL_LSB +: 4] = chanFull[3:0];
        fifoStatus[7:0] = chanNonEmpty & CHANNEL_BITS;
    end

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    assign pcmWrite = rp.wrEn && (rp.wrAddr == PCM_OUT_SAMPLE_OFS);
    assign pcmRead = rp.rdEn && (rp.rdAddr == PCM_OUT_SAMPLE_OFS);
    assign mapWrite = rp.wrEn && (rp.wrAddr == DMA_CHANNEL_MAP_OFS) && rp.wrStrb[0];

    always_comb
    begin
        rp.rdData = 32'h0000_0000;
        rp.rdOk = 1'h1;
        if (rp.rdAddr == SLOT_FIFO_STATUS_OFS)
        begin
            rp.rdData = fifoStatus;
        end
        else if (rp.rdAddr == DMA_REQUEST_STATUS_OFS)
        begin
            rp.rdData = {24'h00_0000, dmaPending_q};
        end
        else if (rp.rdAddr == DMA_CHANNEL_MAP_OFS)
        begin
            rp.rdData = {30'h0000_0000, mapMode_q};
        end
        else if (rp.rdAddr == PCM_OUT_SAMPLE_OFS)
        begin
            // Write-only: reads return zero but still count as an access
            rp.rdData = 32'h0000_0000;
        end
        else
        begin
            rp.rdOk = 1'h0;
        end
    end

    // Writes to the two status registers are ignored but answered OKAY
    always_comb
    begin
        if (rp.wrAddr == SLOT_FIFO_STATUS_OFS)
        begin
            rp.wrOk = 1'h1;
        end
        else if (rp.wrAddr == DMA_REQUEST_STATUS_OFS)
        begin
            rp.wrOk = 1'h1;
        end
        else if (rp.wrAddr == DMA_CHANNEL_MAP_OFS)
        begin
            rp.wrOk = 1'h1;
        end
        else if (rp.wrAddr == PCM_OUT_SAMPLE_OFS)
        begin
            rp.wrOk = 1'h1;
        end
        else
        begin
            rp.wrOk = 1'h0;
        end
    end

    // ----------------------------------------
    // Map mode and PCM sample registers
    // ----------------------------------------
    always_comb
    begin
        mapMode_d = mapMode_q;
        pcmLeft_d = pcmLeft_q;
        pcmRight_d = pcmRight_q;
        pcmValid_d = 1'h0;
        if (mapWrite)
        begin
            mapMode_d = rp.wrData[1:0];
        end
        if (pcmWrite)
        begin
            pcmValid_d = 1'h1;
            if (bigEndian)
            begin
                pcmLeft_d = rp.wrData[31:16];
                pcmRight_d = rp.wrData[15:0];
            end
            else
            begin
                pcmLeft_d = rp.wrData[15:0];
                pcmRight_d = rp.wrData[31:16];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            mapMode_q <= MAP_MODE_RESET;
            pcmLeft_q <= 16'h0000;
            pcmRight_q <= 16'h0000;
            pcmValid_q <= 1'h0;
        end
        else
        begin
            mapMode_q <= mapMode_d;
            pcmLeft_q <= pcmLeft_d;
            pcmRight_q <= pcmRight_d;
            pcmValid_q <= pcmValid_d;
        end
    end

    assign pcmSampleLeft = pcmLeft_q;
    assign pcmSampleRight = pcmRight_q;
    assign pcmSampleValid = pcmValid_q;

    // ----------------------------------------
    // DMA request tracking
    // ----------------------------------------
    // Changing mode does not flush old requests; software drains them first
    assign mapMask = modeMask(mapMode_q);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_chan
            if (TX_CHANNELS[gi])
            begin : g_tx
                assign pendSet[gi] = mapMask[gi] && dmaChanEnable[gi] && !chanFull[gi];
            end
            else
            begin : g_rx
                assign pendSet[gi] = mapMask[gi] && dmaChanEnable[gi] && chanNonEmpty[gi];
            end
        end
    endgenerate

    // PCM clears from our own register and from its external data register; other channels from external data registers only
    always_comb
    begin
        pendClr = sampleAccess;
        pendClr[CH_PCM_TX] = sampleAccess[CH_PCM_TX] || pcmWrite || pcmRead;
        // Set beats clear so a fresh request in the clearing cycle is kept
        // Disabling a channel only stops new sets, never clears
        dmaPending_d = (pendSet | (dmaPending_q & ~pendClr)) & CHANNEL_BITS;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            dmaPending_q <= 8'h00;
        end
        else
        begin
            dmaPending_q <= dmaPending_d;
        end
    end

    assign dmaRequest = dmaPending_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    logic stsRead, reqRead;
    assign stsRead = rp.rdEn && (rp.rdAddr == SLOT_FIFO_STATUS_OFS);
    assign reqRead = rp.rdEn && (rp.rdAddr == DMA_REQUEST_STATUS_OFS);

    AST_MODEM_FULL: assert property (stsRead |=> rdata[14] == $past(chanFull[6]))
        else $error("modem transmit full bit wrong");
    AST_CENTER_LFE_FULL: assert property (stsRead |=> rdata[11:10] == $past(chanFull[3:2]))
        else $error("center or LFE full bit wrong");
    AST_PCM_SURR_FULL: assert property (stsRead |=> rdata[9:8] == $past(chanFull[1:0]))
        else $error("PCM or surround full bit wrong");
    AST_MODEM_RX_FILL: assert property (stsRead |=> rdata[7] == $past(chanNonEmpty[7]))
        else $error("modem receive fill bit wrong");
    AST_MODEM_TX_FILL: assert property (stsRead |=> rdata[6] == $past(chanNonEmpty[6]))
        else $error("modem transmit fill bit wrong");
    AST_AUDIO_RX_FILL: assert property (stsRead |=> rdata[4] == $past(chanNonEmpty[4]))
        else $error("audio receive fill bit wrong");
    AST_TX_FILL: assert property (stsRead |=> rdata[3:0] == $past(chanNonEmpty[3:0]))
        else $error("transmit fill bits wrong");
    AST_STS_RESERVED: assert property (stsRead |=> rdata[31:15] == 17'h0 && rdata[13:12] == 2'h0 && !rdata[5])
        else $error("reserved status bits not zero");
    AST_REQ_READ: assert property (reqRead |=> rdata[7:6] == $past(dmaPending_q[7:6]))
        else $error("modem request bits wrong");
    AST_REQ_LOW: assert property (reqRead |=> rdata[4:0] == $past(dmaPending_q[4:0])
        && rdata[31:8] == 24'h0 && !rdata[5])
        else $error("audio request bits wrong");
    AST_REQ_RO: assert property (rp.wrEn && rp.wrAddr == DMA_REQUEST_STATUS_OFS
        |=> ((dmaPending_q ^ $past(dmaPending_q)) & ~$past(pendSet | pendClr)) == 8'h00)
        else $error("request bits changed by a write");
    AST_REQ_STICKY: assert property (dmaPending_q[6] && !dmaChanEnable[6] && !sampleAccess[6] |=> dmaPending_q[6])
        else $error("pending request lost without sample access");
    AST_PCM_CLEAR: assert property (pcmWrite && !pendSet[0] |=> !dmaPending_q[0])
        else $error("PCM request not cleared by sample write");
    AST_MAP_WRITE: assert property (mapWrite |=> mapMode_q == $past(rp.wrData[1:0]))
        else $error("map mode not stored");
    AST_MAP_GATE: assert property ((dmaPending_q & ~$past(dmaPending_q) & ~$past(mapMask)) == 8'h00)
        else $error("request raised on unmapped channel");
    AST_PCM_PACK: assert property (pcmWrite && !bigEndian |=> pcmSampleValid && pcmSampleLeft == $past(rp.wrData[15:0]))
        else $error("PCM sample packing wrong");
    AST_TX_RAISE: assert property (mapMask[1] && dmaChanEnable[1] && !chanFull[1] |=> dmaPending_q[1])
        else $error("surround request not raised");
    AST_RESET_CLEAR: assert property (disable iff (1'h0) sys_rst |=> dmaPending_q == 8'h00 && mapMode_q == 2'h0)
        else $error("state not cleared by reset");

    COV_MAP_WRITE: cover property (mapWrite ##1 mapMode_q == 2'h3);
    COV_REQ_RISE: cover property (!dmaPending_q[7] ##1 dmaPending_q[7]);
    COV_PCM_WRITE: cover property (pcmWrite ##1 pcmSampleValid);
    COV_REQ_CLEAR: cover property (dmaPending_q[0] ##1 !dmaPending_q[0]);

endmodule

// ### hw/aclink_pkg.sv
//
// Contract
// - Status bit 14 shows modem transmit full
// - Status bits 11,10 show LFE, center full
// - Status bits 9,8 show surround, PCM full
// - Status bit 7 shows modem receive non-empty
// - Status bit 6 shows modem transmit non-empty
// - Status bit 4 shows audio receive non-empty
// - Status bits 3..0 show transmit non-empty
// - Status bits 31:15, 13:12, 5 read zero
// - Request bits 7,6 show modem receive, transmit
// - Request bits 4..0 audio in, LFE..PCM out
// - Request bits read-only, one while pending
// - Pending survives disable; sample access clears it
// - Channel map: two-bit mode in bits 1:0
// - Modes 0 and 1 channel sets
// - Modes 2 and 3 channel sets
// - PCM out register: write-only, two packed samples
package aclink_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [15:0] SLOT_FIFO_STATUS_OFS = 16'hF750;
    localparam logic [15:0] DMA_REQUEST_STATUS_OFS = 16'hF780;
    localparam logic [15:0] DMA_CHANNEL_MAP_OFS = 16'hF784;
    localparam logic [15:0] PCM_OUT_SAMPLE_OFS = 16'hF7A0;

    // ----------------------------------------
    // Channel indices, shared by status and request fields
    // ----------------------------------------
    localparam int CH_PCM_TX = 0;
    localparam int CH_SURROUND_TX = 1;
    localparam int CH_CENTER_TX = 2;
    localparam int CH_LOWFREQ_TX = 3;
    localparam int CH_AUDIO_RX = 4;
    localparam int CH_MODEM_TX = 6;
    localparam int CH_MODEM_RX = 7;
    localparam int NUM_CH = 8;

    localparam logic [7:0] TX_CHANNELS = 8'h4F;
    localparam logic [7:0] CHANNEL_BITS = 8'hDF;

    // ----------------------------------------
    // Status field positions
    // ----------------------------------------
    localparam int MODEM_TX_FULL_BIT = 14;
    localparam int AUDIO_FULL_LSB = 8;

    // ----------------------------------------
    // Mapping modes and reset values
    // ----------------------------------------
    localparam logic [1:0] MAP_MODE_RESET = 2'h0;
    localparam logic [7:0] MODE0_MASK = 8'hD1;
    localparam logic [7:0] MODE1_MASK = 8'hC3;
    localparam logic [7:0] MODE2_MASK = 8'h0F;
    localparam logic [7:0] MODE3_MASK = 8'h17;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic [7:0] modeMask(input logic [1:0] mode);
        logic [7:0] m;
        m = MODE0_MASK;
        case (mode)
            2'h0: m = MODE0_MASK;
            2'h1: m = MODE1_MASK;
            2'h2: m = MODE2_MASK;
            default: m = MODE3_MASK;
        endcase
        return m;
    endfunction

endpackage

// ### hw/reg_port_if.sv
interface reg_port_if;
    logic wrEn;
    logic [15:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic wrOk;
    logic rdEn;
    logic [15:0] rdAddr;
    logic [31:0] rdData;
    logic rdOk;

    modport port
    (
        output wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
        input wrOk, rdData, rdOk
    );
    modport regs
    (
        input wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
        output wrOk, rdData, rdOk
    );
endinterface

// ### hw/axil_slave_port.sv
module axil_slave_port
    import aclink_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Write address and data
    input wire logic [15:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read
    input wire logic [15:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Register side
    reg_port_if.port rp
);

    logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bValid_q, bValid_d, rValid_q, rValid_d;
    logic [15:0] awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d, rData_q, rData_d;
    logic [3:0] wStrb_q, wStrb_d;
    logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;

    // ----------------------------------------
    // Handshake
    // ----------------------------------------
    // Address and data may arrive in either order; one write in flight
    assign awready = !awHeld_q && !bValid_q;
    assign wready = !wHeld_q && !bValid_q;
    assign arready = !rValid_q;
    assign rp.wrEn = awHeld_q && wHeld_q && !bValid_q;
    assign rp.wrAddr = awAddr_q;
    assign rp.wrData = wData_q;
    assign rp.wrStrb = wStrb_q;
    assign rp.rdEn = arvalid && arready;
    assign rp.rdAddr = araddr;
    assign bvalid = bValid_q;
    assign bresp = bResp_q;
    assign rvalid = rValid_q;
    assign rdata = rData_q;
    assign rresp = rResp_q;

    always_comb
    begin
        awHeld_d = awHeld_q;
        wHeld_d = wHeld_q;
        bValid_d = bValid_q;
        rValid_d = rValid_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bResp_d = bResp_q;
        rData_d = rData_q;
        rResp_d = rResp_q;
        if (awvalid && awready)
        begin
            awHeld_d = 1'h1;
            awAddr_d = awaddr;
        end
        if (wvalid && wready)
        begin
            wHeld_d = 1'h1;
            wData_d = wdata;
            wStrb_d = wstrb;
        end
        if (rp.wrEn)
        begin
            awHeld_d = 1'h0;
            wHeld_d = 1'h0;
            bValid_d = 1'h1;
            bResp_d = rp.wrOk ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bValid_q && bready)
        begin
            bValid_d = 1'h0;
        end
        if (rp.rdEn)
        begin
            rValid_d = 1'h1;
            rData_d = rp.rdData;
            rResp_d = rp.rdOk ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rValid_q && rready)
        begin
            rValid_d = 1'h0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            awHeld_q <= 1'h0;
            wHeld_q <= 1'h0;
            bValid_q <= 1'h0;
            rValid_q <= 1'h0;
            awAddr_q <= 16'h0000;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            bResp_q <= RESP_OKAY;
            rData_q <= 32'h0000_0000;
            rResp_q <= RESP_OKAY;
        end
        else
        begin
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            bValid_q <= bValid_d;
            rValid_q <= rValid_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            bResp_q <= bResp_d;
            rData_q <= rData_d;
            rResp_q <= rResp_d;
        end
    end

endmodule

// ### dv/slot_fifo_model.sv
module slot_fifo_model
    import aclink_pkg::*;
#(
    parameter int DEPTH = 4
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Link-side traffic from the bench
    input wire logic [7:0] pushMask,
    input wire logic [7:0] popMask,
    // DMA controller behaviour
    input wire logic serveEn,
    input wire logic [3:0] serveGap,
    input wire logic clearAll,
    input wire logic [7:0] dmaRequest,
    output logic [7:0] sampleAccess,
    // FIFO state seen by the block
    output logic [7:0] chanFull,
    output logic [7:0] chanNonEmpty
);
    timeunit 1ns;
    timeprecision 1ps;

    int level [NUM_CH];
    int gap;
    int lv;
    logic serve;

    initial sampleAccess = 8'h00;

    // ----------------------------------------
    // Service and FIFO levels
    // ----------------------------------------
    // Serving on a stale request only overfills a transmit FIFO or over-drains a receive one, and levels saturate
    always @(posedge ref_clk)
    begin
        serve = !clearAll && serveEn && gap == 0;
        if (sys_rst)
        begin
            foreach (level[i])
                level[i] <= 0;
            gap <= 0;
            sampleAccess <= 8'h00;
        end
        else
        begin
            sampleAccess <= clearAll ? CHANNEL_BITS : (serve ? dmaRequest : 8'h00);
            gap <= (serve && dmaRequest != 8'h00) ? int'(serveGap) : (gap > 0 ? gap - 1 : 0);
            for (int i = 0; i < NUM_CH; i++)
            begin
                lv = level[i] + int'(pushMask[i]) - int'(popMask[i]);
                if (serve && dmaRequest[i])
                    lv = TX_CHANNELS[i] ? lv + 1 : lv - 1;
                level[i] <= (lv < 0) ? 0 : ((lv > DEPTH) ? DEPTH : lv);
            end
        end
    end

    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            chanFull[i] = TX_CHANNELS[i] && level[i] == DEPTH;
            chanNonEmpty[i] = CHANNEL_BITS[i] && level[i] != 0;
        end
    end
endmodule

// ### dv/aclink_fifo_dma_status_tb_top.sv
module aclink_fifo_dma_status_tb_top
    import aclink_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic ref_clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, bigEndian, pcmSampleValid, serveEn, clearAll;
    logic [15:0] awaddr, araddr, pcmSampleLeft, pcmSampleRight;
    logic [31:0] wdata, rdata, d, exp;
    logic [3:0] wstrb, serveGap;
    logic [1:0] bresp, rresp, r, mode;
    logic [7:0] chanFull, chanNonEmpty, dmaChanEnable, sampleAccess, dmaRequest, pushMask, popMask, en;
    int badCount, testsRun, cycles, pcmPulses, n;

    aclink_fifo_dma_status dut
    (
        .ref_clk, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .chanFull, .chanNonEmpty, .dmaChanEnable, .sampleAccess, .dmaRequest,
        .bigEndian, .pcmSampleLeft, .pcmSampleRight, .pcmSampleValid
    );

    slot_fifo_model #(.DEPTH(4)) fifos
    (
        .ref_clk, .sys_rst, .pushMask, .popMask, .serveEn, .serveGap, .clearAll,
        .dmaRequest, .sampleAccess, .chanFull, .chanNonEmpty
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // Expectations and checks
    // ----------------------------------------
    function automatic logic [31:0] expStatus(input logic [7:0] f, input logic [7:0] ne);
        return {17'h0, f[6], 2'h0, f[3:0], ne[7:6], 1'b0, ne[4:0]};
    endfunction

    function automatic logic [31:0] expReq(input logic [1:0] m, input logic [7:0] e, input logic [7:0] f,
                                           input logic [7:0] ne);
        logic [7:0] k;
        k = (m == 2'h0) ? 8'hD1 : (m == 2'h1) ? 8'hC3 : (m == 2'h2) ? 8'h0F : 8'h17;
        return {24'h0, k & e & ((8'h4F & ~f) | (8'h90 & ne))};
    endfunction

    task automatic checkWord(input string what, input logic [31:0] e, input logic [31:0] got);
        testsRun++;
        if (got !== e)
        begin
            badCount++;
            $display("Error %s expected %h seen %h", what, e, got);
        end
    endtask

    task automatic checkResp(input string what, input logic [1:0] e, input logic [1:0] got);
        testsRun++;
        if (got !== e)
        begin
            badCount++;
            $display("Error %s expected %h seen %h", what, e, got);
        end
    endtask

    task automatic endOfTest();
        $display("Checks %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------
    // Bus master
    // ----------------------------------------
    // Handshakes judged at the falling edge, where nothing is moving
    task automatic axiWrite(input logic [15:0] a, input logic [31:0] dv, input logic [3:0] s,
                            output logic [1:0] rs);
        logic aHs, wHs, bHs;
        bHs = 1'b0;
        rs = 2'h3;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= dv;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!bHs)
        begin
            @(negedge ref_clk);
            aHs = awvalid && awready;
            wHs = wvalid && wready;
            bHs = bvalid && bready;
            if (bHs)
                rs = bresp;
            @(posedge ref_clk);
            if (aHs)
                awvalid <= 1'b0;
            if (wHs)
                wvalid <= 1'b0;
            if (bHs)
                bready <= 1'b0;
        end
    endtask

    task automatic axiRead(input logic [15:0] a, output logic [31:0] dv, output logic [1:0] rs);
        logic aHs, rHs;
        rHs = 1'b0;
        rs = 2'h3;
        dv = 32'hFFFFFFFF;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!rHs)
        begin
            @(negedge ref_clk);
            aHs = arvalid && arready;
            rHs = rvalid && rready;
            if (rHs)
                {dv, rs} = {rdata, rresp};
            @(posedge ref_clk);
            if (aHs)
                arvalid <= 1'b0;
            if (rHs)
                rready <= 1'b0;
        end
    endtask

    task automatic clearPending();
        @(posedge ref_clk);
        dmaChanEnable <= 8'h00;
        clearAll <= 1'b1;
        @(posedge ref_clk);
        clearAll <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    // Pops rarer than pushes so that full FIFOs show up
    task automatic shuffle(input int rounds);
        repeat (rounds)
        begin
            @(posedge ref_clk);
            pushMask <= 8'($urandom);
            popMask <= 8'($urandom & $urandom);
        end
        @(posedge ref_clk);
        {pushMask, popMask} <= 16'h0000;
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (pcmSampleValid === 1'b1)
            pcmPulses++;
        if (cycles == 20000)
        begin
            badCount++;
            endOfTest();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'h6E5FDF91));
        {sys_rst, awvalid, wvalid, bready, arvalid, rready, bigEndian, serveEn, clearAll} <= 9'h100;
        {awaddr, araddr, wdata, wstrb, serveGap} <= 72'h0;
        {dmaChanEnable, pushMask, popMask} <= 24'h0;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        axiRead(SLOT_FIFO_STATUS_OFS, d, r);
        checkWord("status after reset", 32'h0, d);
        axiRead(DMA_REQUEST_STATUS_OFS, d, r);
        checkWord("request after reset", 32'h0, d);
        axiRead(DMA_CHANNEL_MAP_OFS, d, r);
        checkWord("map after reset", 32'h0, d);
        axiRead(16'hF790, d, r);
        checkResp("unmapped read", RESP_SLVERR, r);
        axiWrite(DMA_CHANNEL_MAP_OFS, 32'hFFFFFFFE, 4'hF, r);
        checkResp("map write", RESP_OKAY, r);
        axiRead(DMA_CHANNEL_MAP_OFS, d, r);
        checkWord("map field", 32'h2, d);
        axiWrite(DMA_CHANNEL_MAP_OFS, 32'h1, 4'hE, r);
        axiRead(DMA_CHANNEL_MAP_OFS, d, r);
        checkWord("map lane", 32'h2, d);
        for (int i = 0; i < 16; i++)
        begin
            mode = 2'(i);
            clearPending();
            axiRead(DMA_REQUEST_STATUS_OFS, d, r);
            checkWord("request cleared", 32'h0, d);
            axiWrite(DMA_CHANNEL_MAP_OFS, {30'($urandom), mode}, 4'hF, r);
            shuffle(6);
            en = 8'($urandom);
            @(posedge ref_clk);
            dmaChanEnable <= en;
            repeat (3) @(posedge ref_clk);
            exp = expReq(mode, en, chanFull, chanNonEmpty);
            checkWord("request pins", exp, {24'h0, dmaRequest});
            axiRead(DMA_REQUEST_STATUS_OFS, d, r);
            checkWord("request status", exp, d);
            axiRead(SLOT_FIFO_STATUS_OFS, d, r);
            checkWord("fifo status", expStatus(chanFull, chanNonEmpty), d);
            axiWrite(DMA_REQUEST_STATUS_OFS, 32'($urandom), 4'hF, r);
            checkResp("status write", RESP_OKAY, r);
            @(posedge ref_clk);
            dmaChanEnable <= 8'h00;
            repeat (3) @(posedge ref_clk);
            axiRead(DMA_REQUEST_STATUS_OFS, d, r);
            checkWord("request kept", exp, d);
        end
        for (int g = 0; g < 2; g++)
        begin
            clearPending();
            axiWrite(DMA_CHANNEL_MAP_OFS, 32'h2, 4'h1, r);
            @(posedge ref_clk);
            popMask <= 8'hFF;
            repeat (4) @(posedge ref_clk);
            popMask <= 8'h00;
            serveGap <= 4'(g * 5);
            serveEn <= 1'b1;
            dmaChanEnable <= 8'hFF;
            n = 0;
            while (chanFull !== 8'h0F && n < 300)
            begin
                @(posedge ref_clk);
                n++;
            end
            repeat (20) @(posedge ref_clk);
            checkWord("served fill", 32'h0F, {24'h0, chanFull});
            serveEn <= 1'b0;
            clearPending();
            axiRead(DMA_REQUEST_STATUS_OFS, d, r);
            checkWord("request when full", 32'h0, d);
            axiRead(SLOT_FIFO_STATUS_OFS, d, r);
            checkWord("full status", 32'h00000F0F, d);
        end
        for (int e = 0; e < 2; e++)
        begin
            d = $urandom;
            @(posedge ref_clk);
            bigEndian <= e[0];
            axiWrite(PCM_OUT_SAMPLE_OFS, d, 4'hF, r);
            repeat (2) @(posedge ref_clk);
            checkWord("pcm left", {16'h0, e ? d[31:16] : d[15:0]}, {16'h0, pcmSampleLeft});
            checkWord("pcm right", {16'h0, e ? d[15:0] : d[31:16]}, {16'h0, pcmSampleRight});
            checkWord("pcm pulses", 32'(e + 1), 32'(pcmPulses));
        end
        axiRead(PCM_OUT_SAMPLE_OFS, d, r);
        checkWord("pcm readback", 32'h0, d);
        checkResp("pcm read", RESP_OKAY, r);
        endOfTest();
    end
endmodule
